/* src/dos_combiner.sv */
// dos_combiner: one two-operand logic combiner over the 64-code signal vector
// assumes operand codes were screened before they reach this module
`timescale 1ns/1ps
`default_nettype none
module dos_combiner (
  input  wire logic [63:0]      sig_vec,
  input  wire dos_pkg::dos_comb_s cfg,
  output logic                  result
);
  wire a_bit = sig_vec[cfg.operand_a];
  wire b_bit = sig_vec[cfg.operand_b];
  assign result = (cfg.op == dos_pkg::DOS_OP_OR)  ? (a_bit | b_bit) :
                  (cfg.op == dos_pkg::DOS_OP_XOR) ? (a_bit ^ b_bit) :
                  (a_bit & b_bit); // R6
endmodule
`default_nettype wire

/* src/dos_pkg.sv */
// dos_pkg: constants, register map and types for the drive output signal logic
// assumes an APB slave with 32-bit data and a 40 MHz control clock
package dos_pkg;
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned FAN_RUN_MIN = 5;
  localparam longint unsigned FAN_HOLD_CYC = longint'(FAN_RUN_MIN) * 60 * CLK_HZ;
  localparam int unsigned HOUR_S     = 3600;
  localparam longint unsigned HOUR_CYC = longint'(HOUR_S) * CLK_HZ;
  localparam logic [15:0] LVL_FINE_MAX = 16'h270F;
  localparam logic [15:0] LVL_STEP_FINE   = 16'h000A;
  localparam logic [15:0] LVL_STEP_COARSE = 16'h0064;

  localparam logic [11:0] ADDR_SEL       = 12'h000;
  localparam logic [11:0] ADDR_COMB1     = 12'h004;
  localparam logic [11:0] ADDR_COMB2     = 12'h008;
  localparam logic [11:0] ADDR_COMB3     = 12'h00C;
  localparam logic [11:0] ADDR_ZERO_THR  = 12'h010;
  localparam logic [11:0] ADDR_TIME_LVL  = 12'h014;
  localparam logic [11:0] ADDR_FAN       = 12'h018;
  localparam logic [11:0] ADDR_AMBIENT   = 12'h01C;
  localparam logic [11:0] ADDR_STATUS    = 12'h020;
  localparam logic [11:0] ADDR_FAN_TIME  = 12'h024;

  localparam logic [5:0] SIG_RTO  = 6'h0B;
  localparam logic [5:0] SIG_PTO  = 6'h0C;
  localparam logic [5:0] SIG_ZERO = 6'h15;
  localparam logic [5:0] SIG_CMB1 = 6'h21;
  localparam logic [5:0] SIG_CMB3 = 6'h23;
  localparam logic [5:0] SIG_CAPW = 6'h27;
  localparam logic [5:0] SIG_FANW = 6'h28;
  localparam logic [5:0] SIG_R62  = 6'h3E;
  localparam logic [5:0] SIG_NONE = 6'h3F;

  localparam logic [15:0] ZERO_THR_RST = 16'h0000;
  localparam logic [15:0] ZERO_THR_MAX = 16'h2710;
  localparam logic signed [7:0] AMB_MIN = 8'shF6;
  localparam logic signed [7:0] AMB_MAX = 8'sh32;
  localparam logic signed [7:0] AMB_RST = 8'sh28;
  localparam logic [31:0] FAN_LIFE_AT40 = 32'h0000_EA60;

  typedef enum logic [1:0] {
    DOS_OP_AND = 2'b00,
    DOS_OP_OR  = 2'b01,
    DOS_OP_XOR = 2'b10
  } dos_op_e;

  typedef enum logic [1:0] {
    DOS_FAN_ALWAYS = 2'b00,
    DOS_FAN_RUN    = 2'b01,
    DOS_FAN_TEMP   = 2'b10
  } dos_fan_e;

  typedef struct packed {
    logic [5:0] operand_a;
    logic [5:0] operand_b;
    dos_op_e    op;
  } dos_comb_s;

  typedef struct packed {
    logic run;
    logic power_on_hour;
    logic run_hour;
    logic pos_ctrl;
    logic fin_hot;
    logic cap_life_warn;
  } dos_stat_s;
endpackage

/* src/dos_top.sv */
// dos_top: status output generation and routing for output terminals and relay
// assumes APB master on clk; status inputs come from logic on the same clock
// Overview of operation
// (R1) Selector code 11 routes run-time-over, code 12 routes power-on-time-over.
// (R2) Code 21 routes zero-speed flag while frequency is below threshold.
// (R3) Zero-speed compares motor frequency during position control, else output frequency.
// (R4) Codes 33, 34, 35 route combiner one, two, three results.
// (R5) Each combiner has its own operand a, operand b, operator settings.
// (R6) Operator 00 is AND, 01 is OR, 02 is XOR.
// (R7) Operands take codes 0..63 but reject 33..35, 62, 63.
// (R8) Code 39 routes the capacitor life warning.
// (R9) Life monitor shows capacitor and fan life warnings.
// (R10) Fan mode: 00 always, 01 running plus 5 minutes, 02 fin temperature.
// (R11) Writing 01 to fan clear zeroes fan time, then returns to 00.
// (R12) Fan stops during power loss, resumes on its own afterwards.
// (R13) Code 40 routes fan life warning from fan hours and ambient.
// (R14) Ambient setting accepts -10 to 50 degrees, default 40.
// (R15) Time level 0 disables; 10-hour or 100-hour steps; flag when exceeded.
// (R16) Zero-speed drops when compared frequency is at or above threshold.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dos_top #(
  parameter longint unsigned HOUR_CYCLES = dos_pkg::HOUR_CYC,
  parameter longint unsigned FAN_HOLD    = dos_pkg::FAN_HOLD_CYC,
  parameter int unsigned     FREQ_W      = 16
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic [63:0]       ext_sig,
  input  wire dos_pkg::dos_stat_s stat,
  input  wire logic              power_ok,
  input  wire logic [FREQ_W-1:0] out_freq,
  input  wire logic [FREQ_W-1:0] motor_freq,
  output logic                   term_one_out,
  output logic                   term_two_out,
  output logic                   relay_out,
  output logic                   fan_on,
  output logic [1:0]             life_assessment_monitor
);
  // power_ok comes from the supply monitor pin: two flops first
  logic pwr_s1_r;
  logic pwr_s2_r;
  always_ff @(posedge clk) begin
    pwr_s1_r <= sys_rst ? 1'b0 : power_ok;
    pwr_s2_r <= sys_rst ? 1'b0 : pwr_s1_r;
  end

  // settings
  logic [5:0]          output_terminal_one_selector_r;
  logic [5:0]          output_terminal_two_selector_r;
  logic [5:0]          relay_output_selector_r;
  dos_pkg::dos_comb_s  comb_r [3];
  logic [15:0]         zero_frequency_threshold_r;
  logic [15:0]         time_level_setting_r;
  dos_pkg::dos_fan_e   fan_mode_setting_r;
  logic                fan_time_clear_setting_r;
  logic signed [7:0]   ambient_temperature_setting_r;

  // apb decode
  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire hit_sel   = paddr == dos_pkg::ADDR_SEL;
  wire hit_c1    = paddr == dos_pkg::ADDR_COMB1;
  wire hit_c2    = paddr == dos_pkg::ADDR_COMB2;
  wire hit_c3    = paddr == dos_pkg::ADDR_COMB3;
  wire hit_thr   = paddr == dos_pkg::ADDR_ZERO_THR;
  wire hit_lvl   = paddr == dos_pkg::ADDR_TIME_LVL;
  wire hit_fan   = paddr == dos_pkg::ADDR_FAN;
  wire hit_amb   = paddr == dos_pkg::ADDR_AMBIENT;
  wire hit_stat  = paddr == dos_pkg::ADDR_STATUS;
  wire hit_ftime = paddr == dos_pkg::ADDR_FAN_TIME;
  wire hit_any   = hit_sel | hit_c1 | hit_c2 | hit_c3 | hit_thr | hit_lvl |
                   hit_fan | hit_amb | hit_stat | hit_ftime;

  // operand screening: bad codes leave the old value in place
  function automatic logic operand_ok(input logic [5:0] code);
    operand_ok = !((code >= dos_pkg::SIG_CMB1 && code <= dos_pkg::SIG_CMB3) ||
                   code >= dos_pkg::SIG_R62); // R7
  endfunction
  wire [5:0] wa = pwdata[5:0];
  wire [5:0] wb = pwdata[13:8];
  wire [1:0] wop = pwdata[17:16];
  wire comb_ok = operand_ok(wa) && operand_ok(wb) && (wop <= 2'b10);
  wire thr_ok = pwdata[15:0] <= dos_pkg::ZERO_THR_MAX; // R2
  wire signed [7:0] wamb = pwdata[7:0];
  wire amb_ok = (wamb >= dos_pkg::AMB_MIN) && (wamb <= dos_pkg::AMB_MAX); // R14
  wire fan_ok = pwdata[1:0] <= 2'b10;

  wire [2:0] comb_hit = {hit_c3, hit_c2, hit_c1};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cfg
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          comb_r[gi] <= '{operand_a: 6'h00, operand_b: 6'h00,
                          op: dos_pkg::DOS_OP_AND}; // R6
        end else if (wr_acc && comb_hit[gi] && comb_ok) begin
          comb_r[gi] <= '{operand_a: wa, operand_b: wb,
                          op: dos_pkg::dos_op_e'(wop)}; // R5
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      output_terminal_one_selector_r <= dos_pkg::SIG_NONE;
      output_terminal_two_selector_r <= dos_pkg::SIG_NONE;
      relay_output_selector_r        <= dos_pkg::SIG_NONE;
      zero_frequency_threshold_r     <= dos_pkg::ZERO_THR_RST;
      time_level_setting_r           <= 16'h0000;
      fan_mode_setting_r             <= dos_pkg::DOS_FAN_RUN;
      ambient_temperature_setting_r  <= dos_pkg::AMB_RST; // R14
    end else if (wr_acc) begin
      if (hit_sel) begin
        output_terminal_one_selector_r <= pwdata[5:0];
        output_terminal_two_selector_r <= pwdata[13:8];
        relay_output_selector_r        <= pwdata[21:16];
      end
      if (hit_thr && thr_ok) zero_frequency_threshold_r <= pwdata[15:0];
      if (hit_lvl) time_level_setting_r <= pwdata[15:0];
      if (hit_fan && fan_ok) fan_mode_setting_r <= dos_pkg::dos_fan_e'(pwdata[1:0]);
      if (hit_amb && amb_ok) ambient_temperature_setting_r <= wamb;
    end
  end

  // clear request self-returns to zero the cycle after it acts
  always_ff @(posedge clk) begin
    if (sys_rst) fan_time_clear_setting_r <= 1'b0;
    else fan_time_clear_setting_r <= wr_acc && hit_fan && (pwdata[9:8] == 2'b01); // R11
  end

  // time-over flags: level in hours is 10x or 100x the setting
  wire [23:0] lvl_hours = (time_level_setting_r > dos_pkg::LVL_FINE_MAX) ?
                          24'(time_level_setting_r) * 24'(dos_pkg::LVL_STEP_COARSE) :
                          24'(time_level_setting_r) * 24'(dos_pkg::LVL_STEP_FINE); // R15
  wire lvl_on = time_level_setting_r != 16'h0000;
  // strict compare: reaching the level is not yet over
  logic [23:0] run_hours_r;
  logic [23:0] on_hours_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_hours_r <= 24'h000000;
      on_hours_r  <= 24'h000000;
    end else begin
      if (stat.run_hour && run_hours_r != 24'hFFFFFF) run_hours_r <= run_hours_r + 24'h000001;
      if (stat.power_on_hour && on_hours_r != 24'hFFFFFF) on_hours_r <= on_hours_r + 24'h000001;
    end
  end
  wire run_time_over_flag      = lvl_on && (run_hours_r > lvl_hours); // R15
  wire power_on_time_over_flag = lvl_on && (on_hours_r > lvl_hours);  // R15

  // zero speed
  wire [FREQ_W-1:0] cmp_freq = stat.pos_ctrl ? motor_freq : out_freq; // R3
  wire zero_speed_flag = cmp_freq < FREQ_W'(zero_frequency_threshold_r); // R2 R16

  // fan control and its operating-hour counter
  logic [39:0] fan_hold_r;
  logic        fan_nxt;
  logic        run_d_r;
  always_comb begin
    case (fan_mode_setting_r)
      dos_pkg::DOS_FAN_ALWAYS: fan_nxt = 1'b1;
      dos_pkg::DOS_FAN_RUN:    fan_nxt = stat.run || run_d_r || (fan_hold_r != 40'h0);
      dos_pkg::DOS_FAN_TEMP:   fan_nxt = stat.fin_hot;
      default:                 fan_nxt = 1'b1;
    endcase
  end // R10
  // run_d_r bridges the stop cycle before the hold count is loaded
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fan_hold_r <= 40'(FAN_HOLD); // R10
      run_d_r    <= 1'b0;
      fan_on     <= 1'b0;
    end else begin
      run_d_r <= stat.run;
      if (run_d_r && !stat.run) fan_hold_r <= 40'(FAN_HOLD);
      else if (fan_hold_r != 40'h0) fan_hold_r <= fan_hold_r - 40'h1;
      fan_on <= fan_nxt && pwr_s2_r; // R12
    end
  end

  logic [39:0] fan_tick_r;
  logic [31:0] fan_hours_r;
  always_ff @(posedge clk) begin
    if (sys_rst || fan_time_clear_setting_r) begin
      fan_tick_r  <= 40'h0;
      fan_hours_r <= 32'h0; // R11
    end else if (fan_on) begin
      if (fan_tick_r == 40'(HOUR_CYCLES - 1)) begin
        fan_tick_r  <= 40'h0;
        fan_hours_r <= fan_hours_r + 32'h1;
      end else begin
        fan_tick_r <= fan_tick_r + 40'h1;
      end
    end
  end
  // life halves for any setting above 40, doubles for any below; coarse on purpose
  wire signed [8:0] amb_dev = 9'(ambient_temperature_setting_r) - 9'(dos_pkg::AMB_RST);
  wire [31:0] fan_life = (amb_dev > 9'sd0) ? (dos_pkg::FAN_LIFE_AT40 >> 1) :
                         (amb_dev < 9'sd0) ? (dos_pkg::FAN_LIFE_AT40 << 1) :
                         dos_pkg::FAN_LIFE_AT40;
  wire fan_life_warning       = fan_hours_r >= fan_life; // R13
  wire capacitor_life_warning = stat.cap_life_warn; // R8

  // signal vector and combiners
  logic [63:0] sig_vec;
  logic [2:0]  comb_out;
  always_comb begin
    sig_vec = ext_sig;
    sig_vec[dos_pkg::SIG_RTO]  = run_time_over_flag; // R1
    sig_vec[dos_pkg::SIG_PTO]  = power_on_time_over_flag; // R1
    sig_vec[dos_pkg::SIG_ZERO] = zero_speed_flag; // R2
    sig_vec[dos_pkg::SIG_CAPW] = capacitor_life_warning; // R8
    sig_vec[dos_pkg::SIG_FANW] = fan_life_warning; // R13
    sig_vec[dos_pkg::SIG_CMB1 + 6'd0] = comb_out[0]; // R4
    sig_vec[dos_pkg::SIG_CMB1 + 6'd1] = comb_out[1]; // R4
    sig_vec[dos_pkg::SIG_CMB1 + 6'd2] = comb_out[2]; // R4
    sig_vec[dos_pkg::SIG_R62]  = 1'b0;
    sig_vec[dos_pkg::SIG_NONE] = 1'b0;
  end
  // operands never point at combiner outputs, so no loop exists
  wire [63:0] operand_vec = {sig_vec[63:36], 3'b000, sig_vec[32:0]};
  generate
    for (gi = 0; gi < 3; gi++) begin : g_comb
      dos_combiner u_comb (
        .sig_vec (operand_vec),
        .cfg     (comb_r[gi]),
        .result  (comb_out[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      term_one_out            <= 1'b0;
      term_two_out            <= 1'b0;
      relay_out               <= 1'b0;
      life_assessment_monitor <= 2'b00;
    end else begin
      term_one_out <= sig_vec[output_terminal_one_selector_r]; // R1 R4
      term_two_out <= sig_vec[output_terminal_two_selector_r];
      relay_out    <= sig_vec[relay_output_selector_r];
      life_assessment_monitor <= {fan_life_warning, capacitor_life_warning}; // R9
    end
  end

  // apb: zero wait states, unmapped reads zero with error
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit_sel)   rd_mux = {10'h0, relay_output_selector_r, 2'b00,
                             output_terminal_two_selector_r, 2'b00,
                             output_terminal_one_selector_r};
    if (hit_c1)    rd_mux = {14'h0, comb_r[0].op, 2'b00, comb_r[0].operand_b,
                             2'b00, comb_r[0].operand_a};
    if (hit_c2)    rd_mux = {14'h0, comb_r[1].op, 2'b00, comb_r[1].operand_b,
                             2'b00, comb_r[1].operand_a};
    if (hit_c3)    rd_mux = {14'h0, comb_r[2].op, 2'b00, comb_r[2].operand_b,
                             2'b00, comb_r[2].operand_a};
    if (hit_thr)   rd_mux = {16'h0, zero_frequency_threshold_r};
    if (hit_lvl)   rd_mux = {16'h0, time_level_setting_r};
    if (hit_fan)   rd_mux = {22'h0, 1'b0, fan_time_clear_setting_r, 6'h0, fan_mode_setting_r};
    if (hit_amb)   rd_mux = {{24{ambient_temperature_setting_r[7]}},
                             ambient_temperature_setting_r};
    if (hit_stat)  rd_mux = {24'h0, run_time_over_flag, power_on_time_over_flag, zero_speed_flag,
                             comb_out, fan_life_warning, capacitor_life_warning}; // R9
    if (hit_ftime) rd_mux = fan_hours_r;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
      pslverr <= psel && !penable && !hit_any;
    end
  end
  wire unused_ok = rd_acc;
endmodule
`default_nettype wire

/* verif/dos_checker.sv */
// dos_checker: concurrent checks on the ports of dos_top
// assumes a single apb master; snoops writes to predict routed outputs
`timescale 1ns/1ps
`default_nettype none
module dos_checker #(
  parameter int unsigned FREQ_W = 16
) (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  input wire logic [63:0]        ext_sig,
  input wire dos_pkg::dos_stat_s stat,
  input wire logic               power_ok,
  input wire logic [FREQ_W-1:0]  out_freq,
  input wire logic [FREQ_W-1:0]  motor_freq,
  input wire logic               term_one_out,
  input wire logic               term_two_out,
  input wire logic               relay_out,
  input wire logic               fan_on,
  input wire logic [1:0]         life_assessment_monitor
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [5:0]  sel1_r;
  logic [5:0]  selr_r;
  logic [15:0] thr_r;
  wire         wr_acc = psel && penable && pready && pwrite;
  wire         thr_ok = pwdata[15:0] <= dos_pkg::ZERO_THR_MAX;
  wire [31:0]  cmp_f  = 32'(stat.pos_ctrl ? motor_freq : out_freq);
  wire         zero_exp = cmp_f < 32'(thr_r);
  // shadow copies only; refused threshold writes must not move them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {sel1_r, selr_r, thr_r} <= {6'h3F, 6'h3F, 16'h0000};
    end else if (wr_acc && paddr == dos_pkg::ADDR_SEL) begin
      {selr_r, sel1_r} <= {pwdata[21:16], pwdata[5:0]};
    end else if (wr_acc && paddr == dos_pkg::ADDR_ZERO_THR && thr_ok) begin
      thr_r <= pwdata[15:0];
    end
  end
  pready_answer_a: assert property (psel && !penable |=> pready)
    else $error("no pready in access cycle");
  pready_cause_a: assert property (pready |-> $past(psel) && !$past(penable) && !$past(pready))
    else $error("pready without setup cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside access cycle");
  unmapped_err_a: assert property (pready && paddr > dos_pkg::ADDR_FAN_TIME |-> pslverr)
    else $error("unmapped access without pslverr");
  reset_quiet_a: assert property ($fell(sys_rst) |->
    !term_one_out && !term_two_out && !relay_out && life_assessment_monitor == 2'b00)
    else $error("outputs not quiet after reset");
  cap_monitor_a: assert property (!$past(sys_rst) |->
    life_assessment_monitor[0] == $past(stat.cap_life_warn))
    else $error("life monitor misses capacitor warning");
  fan_power_loss_a: assert property ((!power_ok) [*4] |=> !fan_on)
    else $error("fan runs without power");
  route_cap_warn_a: assert property ($past(sel1_r) == dos_pkg::SIG_CAPW && !$past(sys_rst) |->
    term_one_out == $past(stat.cap_life_warn))
    else $error("capacitor warning not routed");
  zero_speed_a: assert property ($past(selr_r) == dos_pkg::SIG_ZERO && !$past(sys_rst) |->
    relay_out == $past(zero_exp))
    else $error("zero speed flag wrong on relay");
endmodule

bind dos_top dos_checker #(.FREQ_W(FREQ_W)) u_dos_checker (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .ext_sig(ext_sig), .stat(stat), .power_ok(power_ok), .out_freq(out_freq),
  .motor_freq(motor_freq), .term_one_out(term_one_out), .term_two_out(term_two_out),
  .relay_out(relay_out), .fan_on(fan_on), .life_assessment_monitor(life_assessment_monitor)
);
`default_nettype wire

/* verif/tb_top.sv */
// tb_top: self-checking bench for dos_top over apb
// assumes dos_pkg compiled first; short hour and fan hold counts
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned HOLD = 20;
  logic               clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic               pready;
  logic [31:0]        prdata;
  logic               pslverr;
  logic [63:0]        ext_sig = 64'h0;
  dos_pkg::dos_stat_s stat = '0;
  logic               power_ok = 1'b1;
  logic [15:0]        out_freq = 16'h0000;
  logic [15:0]        motor_freq = 16'h0000;
  logic               term_one_out;
  logic               term_two_out;
  logic               relay_out;
  logic               fan_on;
  logic [1:0]         life_assessment_monitor;
  int                 n_mismatch = 0;
  int                 samples_checked = 0;
  int                 cyc = 0;
  logic [31:0]        seed = 32'h0000_C792;
  logic [31:0]        rd;
  logic [31:0]        r;
  logic               err;
  logic [5:0]         c1;
  logic [5:0]         c2;
  logic [5:0]         c3;
  logic [15:0]        thr;
  logic [11:0]        ca;
  logic [7:0]         amb_in [4] = '{8'hF5, 8'h32, 8'h33, 8'hF6};
  logic [7:0]         amb_ex [4] = '{8'h28, 8'h32, 8'h32, 8'hF6};

  always #12.5 clk = ~clk;

  dos_top #(.HOUR_CYCLES(4), .FAN_HOLD(HOLD), .FREQ_W(16)) dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_sig(ext_sig), .stat(stat), .power_ok(power_ok), .out_freq(out_freq),
    .motor_freq(motor_freq), .term_one_out(term_one_out), .term_two_out(term_two_out),
    .relay_out(relay_out), .fan_on(fan_on), .life_assessment_monitor(life_assessment_monitor)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic comb_exp(input logic [1:0] op, input logic a, input logic b);
    return op == 2'h0 ? a & b : op == 2'h1 ? a | b : a ^ b;
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // idle edge first so release and next setup never share a time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) chk(32'h0, 32'h1, "apb timeout");
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask

  task automatic hours(input int n, input logic on);
    repeat (n) begin
      @(posedge clk);
      {stat.power_on_hour, stat.run_hour} <= {on, !on};
      @(posedge clk);
      {stat.power_on_hour, stat.run_hour} <= 2'b00;
    end
    repeat (3) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(fan_on), 32'h1, "fan after power-on");
    chk(32'({term_one_out, term_two_out, relay_out}), 32'h0, "unassigned outputs");
    rdchk(dos_pkg::ADDR_SEL, 32'h003F_3F3F, "selector reset");
    rdchk(dos_pkg::ADDR_COMB2, 32'h0, "combiner reset");
    rdchk(dos_pkg::ADDR_ZERO_THR, 32'h0, "threshold reset");
    rdchk(dos_pkg::ADDR_TIME_LVL, 32'h0, "time level reset");
    rdchk(dos_pkg::ADDR_FAN, 32'h1, "fan reset");
    rdchk(dos_pkg::ADDR_AMBIENT, 32'h28, "ambient reset");
    apb(1'b0, 12'h030, 32'h0);
    chk(32'(err), 32'h1, "unmapped address");
    repeat (HOLD) @(posedge clk);
    chk(32'(fan_on), 32'h0, "fan power-on hold over");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      {c1, c2, c3} = {6'(xs() % 11), 6'(xs() % 11), 6'(xs() % 11)};
      apb(1'b1, dos_pkg::ADDR_SEL, {10'h0, c3, 2'h0, c2, 2'h0, c1});
      ext_sig <= {xs(), xs()};
      repeat (2) @(posedge clk);
      chk(32'({term_one_out, term_two_out, relay_out}),
          32'({ext_sig[c1], ext_sig[c2], ext_sig[c3]}), "routing");
    end
    $display("test routing done");
    apb(1'b1, dos_pkg::ADDR_SEL, 32'h0000_0C0B);
    hours(11, 1'b1);
    chk(32'(term_two_out), 32'h0, "level zero disables");
    apb(1'b1, dos_pkg::ADDR_TIME_LVL, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'({term_one_out, term_two_out}), 32'h1, "power-on time over");
    hours(10, 1'b0);
    chk(32'(term_one_out), 32'h0, "run time at level");
    hours(1, 1'b0);
    chk(32'(term_one_out), 32'h1, "run time over");
    $display("test time over done");
    apb(1'b1, dos_pkg::ADDR_SEL, 32'h0015_0000);
    apb(1'b1, dos_pkg::ADDR_ZERO_THR, 32'h2710);
    apb(1'b1, dos_pkg::ADDR_ZERO_THR, 32'h2711);
    rdchk(dos_pkg::ADDR_ZERO_THR, 32'h2710, "threshold range");
    for (int i = 0; i < 10; i++) begin
      r = xs();
      thr = (i == 0) ? 16'h2710 : r[31:16] % 16'h2711;
      apb(1'b1, dos_pkg::ADDR_ZERO_THR, {16'h0, thr});
      stat.pos_ctrl <= r[0];
      out_freq <= thr + {13'h0, r[3:1]} - 16'h0003;
      motor_freq <= thr + {13'h0, r[6:4]} - 16'h0003;
      repeat (2) @(posedge clk);
      chk(32'(relay_out), 32'((stat.pos_ctrl ? motor_freq : out_freq) < thr), "zero speed");
    end
    $display("test zero speed done");
    for (int k = 0; k < 3; k++) begin
      ca = dos_pkg::ADDR_COMB1 + 12'(4 * k);
      apb(1'b1, dos_pkg::ADDR_SEL, {26'h0, 6'h21 + 6'(k)});
      for (int o = 0; o < 3; o++) begin
        {c1, c2} = {6'(xs() % 11), 6'(xs() % 11)};
        apb(1'b1, ca, {14'h0, o[1:0], 2'h0, c2, 2'h0, c1});
        ext_sig <= {xs(), xs()};
        repeat (2) @(posedge clk);
        chk(32'(term_one_out), 32'(comb_exp(o[1:0], ext_sig[c1], ext_sig[c2])), "combiner");
      end
      apb(1'b1, ca, {18'h0, 6'h21 + 6'(k), 2'h0, c1});
      apb(1'b1, ca, {18'h0, c2, 2'h0, 6'h3E + 6'(k[0])});
      apb(1'b1, ca, {14'h0, 2'h3, 16'h0});
      rdchk(ca, {14'h0, 2'h2, 2'h0, c2, 2'h0, c1}, "operand refused");
    end
    $display("test combiner done");
    apb(1'b1, dos_pkg::ADDR_SEL, 32'h0028_2727);
    stat.cap_life_warn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'({term_two_out, relay_out, life_assessment_monitor}), 32'h9, "life warnings");
    stat.cap_life_warn <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({term_two_out, life_assessment_monitor}), 32'h0, "capacitor warning off");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, dos_pkg::ADDR_AMBIENT, {24'h0, amb_in[i]});
      apb(1'b0, dos_pkg::ADDR_AMBIENT, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, amb_ex[i]}, "ambient range");
    end
    $display("test warnings done");
    apb(1'b1, dos_pkg::ADDR_FAN, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(fan_on), 32'h1, "fan always");
    power_ok <= 1'b0;
    repeat (6) @(posedge clk);
    chk(32'(fan_on), 32'h0, "fan stops on power loss");
    power_ok <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(fan_on), 32'h1, "fan resumes");
    apb(1'b1, dos_pkg::ADDR_FAN, 32'h3);
    rdchk(dos_pkg::ADDR_FAN, 32'h0, "fan mode refused");
    apb(1'b1, dos_pkg::ADDR_FAN, 32'h1);
    stat.run <= 1'b1;
    repeat (3) @(posedge clk);
    stat.run <= 1'b0;
    repeat (HOLD - 5) @(posedge clk);
    chk(32'(fan_on), 32'h1, "fan hold after stop");
    repeat (10) @(posedge clk);
    chk(32'(fan_on), 32'h0, "fan hold over");
    apb(1'b1, dos_pkg::ADDR_FAN, 32'h2);
    stat.fin_hot <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(fan_on), 32'h1, "fan hot fin");
    stat.fin_hot <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(fan_on), 32'h0, "fan cool fin");
    apb(1'b0, dos_pkg::ADDR_FAN_TIME, 32'h0);
    chk(32'(rd != 32'h0), 32'h1, "fan hours counted");
    apb(1'b1, dos_pkg::ADDR_FAN, 32'h0102);
    rdchk(dos_pkg::ADDR_FAN, 32'h2, "clear returns to zero");
    rdchk(dos_pkg::ADDR_FAN_TIME, 32'h0, "fan hours cleared");
    $display("test fan done");
    print_verdict();
  end
endmodule
`default_nettype wire
